// ---- logic/pmt8_map.svh ----
// register offsets, bus widths, reset values and timing counts of the period timer
`ifndef PMT8_MAP_SVH
`define PMT8_MAP_SVH
`define PMT_N_TIMERS 5
`define PMT_ADDR_W 5
`define PMT_DATA_W 8
`define PMT_OFF_COUNT 2'h0
`define PMT_OFF_PERIOD 2'h1
`define PMT_OFF_CTRL 2'h2
`define PMT_FLAG_ADDR 5'h14
`define PMT_ENABLE_ADDR 5'h15
`define PMT_COUNT_RST 8'h00
`define PMT_PERIOD_RST 8'hff
`define PMT_CTRL_RST 7'h00
`define PMT_INST_DIV 4
`define PMT_PHASE_LAST 2'h3
`define PMT_PRE_LIM_1 6'h00
`define PMT_PRE_LIM_4 6'h03
`define PMT_PRE_LIM_16 6'h0f
`define PMT_PRE_LIM_64 6'h3f
`endif

// ---- logic/pmt8_pkg.sv ----
// types shared by the period timer design
package pmt8_pkg;
  typedef enum logic [1:0] {
    PMT_PRE_DIV1 = 2'b00,
    PMT_PRE_DIV4 = 2'b01,
    PMT_PRE_DIV16 = 2'b10,
    PMT_PRE_DIV64 = 2'b11
  } pmt_pre_type;
  typedef struct packed {
    logic [3:0] postscale_select;
    logic timer_run_bit;
    pmt_pre_type prescale_select;
  } pmt_ctrl_type;
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pmt_bus_type;
endpackage : pmt8_pkg

// ---- logic/pmt8_timers.sv ----
// five 8-bit period match timers with prescaler, postscaler and register port
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "pmt8_map.svh"
module pmt8_timers (
  // clock, reset, clock enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // processor state
  input wire logic sleep,
  // register port
  input wire pmt8_pkg::pmt_bus_type bus,
  output logic [7:0] rdata,
  // interrupt requests, one per timer
  output logic [4:0] irq_req,
  // unscaled match pulses to the capture/compare/PWM units
  output logic [4:0] match_pulse,
  // shift clock for the serial port, from the first timer only
  output logic spi_shift_clk
);
  localparam int N = `PMT_N_TIMERS;

  // prescaler terminal count for the selected ratio
  function automatic logic [5:0] pmt_pre_limit(input pmt8_pkg::pmt_pre_type sel);
    logic [5:0] lim;
    lim = `PMT_PRE_LIM_1;
    unique case (sel)
      pmt8_pkg::PMT_PRE_DIV1: lim = `PMT_PRE_LIM_1;
      pmt8_pkg::PMT_PRE_DIV4: lim = `PMT_PRE_LIM_4;
      pmt8_pkg::PMT_PRE_DIV16: lim = `PMT_PRE_LIM_16;
      pmt8_pkg::PMT_PRE_DIV64: lim = `PMT_PRE_LIM_64;
    endcase
    return lim;
  endfunction : pmt_pre_limit

  // byte address of a per-timer register: four addresses per timer
  function automatic logic [4:0] pmt_addr(input int unsigned idx, input logic [1:0] off);
    logic [2:0] i3;
    i3 = idx[2:0];
    return {i3, off};
  endfunction : pmt_addr

  logic [1:0] phase_q;
  logic inst_tick;
  logic [7:0] cnt_q [N];
  logic [7:0] per_q [N];
  pmt8_pkg::pmt_ctrl_type ctrl_q [N];
  logic [5:0] pre_q [N];
  logic [3:0] post_q [N];
  logic [4:0] flag_q;
  logic [4:0] en_q;
  logic [4:0] tick;
  logic [4:0] hitm;
  logic [4:0] post_hit;
  logic [4:0] wr_cnt;
  logic [4:0] wr_per;
  logic [4:0] wr_ctl;
  logic wr_flag;
  logic wr_en;
  logic [7:0] rd_d;
  logic [7:0] rdata_q;
  logic [4:0] irq_q;
  logic [4:0] match_q;
  logic spi_q;

  // instruction clock as a one-in-four enable, so the timers share the system clock domain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= 2'h0;
    end else if (ce) begin
      phase_q <= phase_q + 2'h1;
    end
  end
  assign inst_tick = ce && (phase_q == `PMT_PHASE_LAST);

  assign wr_flag = bus.wr && (bus.addr == `PMT_FLAG_ADDR);
  assign wr_en = bus.wr && (bus.addr == `PMT_ENABLE_ADDR);

  always_comb begin
    for (int i = 0; i < N; i++) begin
      wr_cnt[i] = bus.wr && (bus.addr == pmt_addr(i, `PMT_OFF_COUNT));
      wr_per[i] = bus.wr && (bus.addr == pmt_addr(i, `PMT_OFF_PERIOD));
      wr_ctl[i] = bus.wr && (bus.addr == pmt_addr(i, `PMT_OFF_CTRL));
      // run bit and sleep gate the prescaler input; no other clock source exists
      tick[i] = inst_tick && ctrl_q[i].timer_run_bit && !sleep &&
                (pre_q[i] == pmt_pre_limit(ctrl_q[i].prescale_select));
      hitm[i] = tick[i] && (cnt_q[i] == per_q[i]);
      post_hit[i] = hitm[i] && (post_q[i] == ctrl_q[i].postscale_select);
    end
  end

  // prescaler: cleared by counter or control writes, holds while stopped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < N; i++) pre_q[i] <= 6'h00;
    end else if (ce) begin
      for (int i = 0; i < N; i++) begin
        if (wr_cnt[i] || wr_ctl[i]) begin
          pre_q[i] <= 6'h00;
        end else if (tick[i]) begin
          pre_q[i] <= 6'h00;
        end else if (inst_tick && ctrl_q[i].timer_run_bit && !sleep) begin
          pre_q[i] <= pre_q[i] + 6'h01;
        end
      end
    end
  end

  // counter: a software write wins over a hardware step in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < N; i++) cnt_q[i] <= `PMT_COUNT_RST;
    end else if (ce) begin
      for (int i = 0; i < N; i++) begin
        if (wr_cnt[i]) begin
          cnt_q[i] <= bus.wdata;
        end else if (hitm[i]) begin
          cnt_q[i] <= 8'h00;
        end else if (tick[i]) begin
          cnt_q[i] <= cnt_q[i] + 8'h01;
        end
      end
    end
  end

  // period and control registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < N; i++) begin
        per_q[i] <= `PMT_PERIOD_RST;
        ctrl_q[i] <= `PMT_CTRL_RST;
      end
    end else if (ce) begin
      for (int i = 0; i < N; i++) begin
        if (wr_per[i]) per_q[i] <= bus.wdata;
        if (wr_ctl[i]) ctrl_q[i] <= bus.wdata[6:0];
      end
    end
  end

  // postscaler counts matches and restarts when it raises the flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < N; i++) post_q[i] <= 4'h0;
    end else if (ce) begin
      for (int i = 0; i < N; i++) begin
        if (wr_cnt[i] || wr_ctl[i]) begin
          post_q[i] <= 4'h0;
        end else if (post_hit[i]) begin
          post_q[i] <= 4'h0;
        end else if (hitm[i]) begin
          post_q[i] <= post_q[i] + 4'h1;
        end
      end
    end
  end

  // flags: a set in the cycle of a software clear still lands
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= 5'h00;
    end else if (ce) begin
      if (wr_flag) begin
        flag_q <= bus.wdata[4:0] | post_hit;
      end else begin
        flag_q <= flag_q | post_hit;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= 5'h00;
    end else if (ce && wr_en) begin
      en_q <= bus.wdata[4:0];
    end
  end

  // interrupt requests and unscaled timer outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 5'h00;
      match_q <= 5'h00;
    end else if (ce) begin
      irq_q <= flag_q & en_q;
      match_q <= hitm;
    end
  end

  // the shift clock toggles per first-timer match, giving half the match rate
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      spi_q <= 1'b0;
    end else if (ce && hitm[0]) begin
      spi_q <= !spi_q;
    end
  end

  // read data stand only in the cycle after the strobe; unmapped reads give zero
  always_comb begin
    rd_d = 8'h00;
    if (bus.rd) begin
      if (bus.addr == `PMT_FLAG_ADDR) rd_d = {3'h0, flag_q};
      if (bus.addr == `PMT_ENABLE_ADDR) rd_d = {3'h0, en_q};
      for (int i = 0; i < N; i++) begin
        if (bus.addr == pmt_addr(i, `PMT_OFF_COUNT)) rd_d = cnt_q[i];
        if (bus.addr == pmt_addr(i, `PMT_OFF_PERIOD)) rd_d = per_q[i];
        if (bus.addr == pmt_addr(i, `PMT_OFF_CTRL)) rd_d = {1'b0, ctrl_q[i]};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (ce) begin
      rdata_q <= rd_d;
    end
  end

  assign rdata = rdata_q;
  assign irq_req = irq_q;
  assign match_pulse = match_q;
  assign spi_shift_clk = spi_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_first_match;
    ce && hitm[0] && !wr_cnt[0];
  endsequence

  sequence s_div4_tick;
    ce && tick[0] && ctrl_q[0].prescale_select == pmt8_pkg::PMT_PRE_DIV4;
  endsequence

  sequence s_post_step;
    ce && hitm[0] && !post_hit[0] && !wr_cnt[0] && !wr_ctl[0];
  endsequence

  chk_match_reload: assert property (s_first_match |=> cnt_q[0] == 8'h00)
    else $error("counter not reloaded after match");
  chk_count_step: assert property (ce && tick[1] && !hitm[1] && !wr_cnt[1]
      |=> cnt_q[1] == $past(cnt_q[1]) + 8'h01)
    else $error("counter did not step by one");
  chk_ctl_keeps: assert property (ce && wr_ctl[0] && !tick[0]
      |=> cnt_q[0] == $past(cnt_q[0]) && pre_q[0] == 6'h00 && post_q[0] == 4'h0)
    else $error("control write disturbed counter or kept scalers");
  chk_cnt_write: assert property (ce && wr_cnt[2]
      |=> cnt_q[2] == $past(bus.wdata) && pre_q[2] == 6'h00 && post_q[2] == 4'h0)
    else $error("counter write wrong");
  chk_flag_set: assert property (ce && post_hit[0] |=> flag_q[0])
    else $error("flag not set at postscale terminal");
  chk_flag_sticky: assert property (flag_q[0] && !wr_flag |=> flag_q[0])
    else $error("flag cleared by hardware");
  chk_irq_gate: assert property (ce |=> irq_req == $past(flag_q & en_q))
    else $error("interrupt request not gated by enable");
  chk_sleep_hold: assert property (ce && sleep && !bus.wr
      |=> cnt_q[0] == $past(cnt_q[0]) && pre_q[0] == $past(pre_q[0]))
    else $error("timer moved during sleep");
  chk_match_out: assert property (s_first_match
      |=> match_pulse[0] ##1 (!match_pulse[0] || $past(hitm[0] || !ce)))
    else $error("match pulse missing or stretched");
  // a control write may change the ratio inside the gap, so it ends the check
  chk_pre_div4: assert property (disable iff (!rst_b || wr_ctl[0])
      s_div4_tick |=> (!tick[0]) [*8] ##1 (!tick[0]) [*7])
    else $error("prescale four tick spacing wrong");
  chk_post_step: assert property (s_post_step
      |=> post_q[0] == $past(post_q[0]) + 4'h1)
    else $error("postscaler did not step on match");
  chk_run_hold: assert property (ce && !ctrl_q[0].timer_run_bit && !bus.wr
      |=> cnt_q[0] == $past(cnt_q[0]) && pre_q[0] == $past(pre_q[0]) && post_q[0] == $past(post_q[0]))
    else $error("stopped timer moved");
  chk_spi_only: assert property (ce
      |=> (spi_shift_clk != $past(spi_shift_clk)) == $past(hitm[0]))
    else $error("shift clock toggled without first timer match");
  chk_rd_idle: assert property (ce && !bus.rd
      |=> rdata == 8'h00)
    else $error("read data outside read cycle");
  chk_flag_clear: assert property (ce && wr_flag && !bus.wdata[0] && !post_hit[0]
      |=> !flag_q[0])
    else $error("software clear of flag lost");
endmodule : pmt8_timers
`default_nettype wire

// ---- sim/pmt8_far_model.sv ----
// far-side model: pwm unit of the first timer and serial port watching the timer outputs
`timescale 1ns/1ns
`default_nettype none
module pmt8_far_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // timer outputs
  input wire logic [4:0] match_pulse,
  input wire logic spi_shift_clk,
  // observed counts
  output logic [15:0] m0_cnt,
  output logic [15:0] tg_cnt
);
  logic spi_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      m0_cnt <= 16'h0000;
      tg_cnt <= 16'h0000;
      spi_q <= 1'b0;
    end else begin
      spi_q <= spi_shift_clk;
      if (match_pulse[0]) begin
        m0_cnt <= m0_cnt + 16'h0001;
      end
      // an edge either way is one shift clock step
      if (spi_shift_clk !== spi_q) begin
        tg_cnt <= tg_cnt + 16'h0001;
      end
    end
  end
endmodule : pmt8_far_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking testbench for the five period match timers
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic sleep = 1'b0;
  pmt8_pkg::pmt_bus_type bus = '0;
  logic [7:0] rdata;
  logic [4:0] irq_req;
  logic [4:0] match_pulse;
  logic spi_shift_clk;
  logic [15:0] m0_cnt;
  logic [15:0] tg_cnt;
  int failures = 0;
  int checks_done = 0;
  pmt8_timers pmt8_timers_i (.clk(clk), .rst_b(rst_b), .ce(ce), .sleep(sleep), .bus(bus),
    .rdata(rdata), .irq_req(irq_req), .match_pulse(match_pulse),
    .spi_shift_clk(spi_shift_clk));
  pmt8_far_model pmt8_far_model_i (.clk(clk), .rst_b(rst_b), .match_pulse(match_pulse),
    .spi_shift_clk(spi_shift_clk), .m0_cnt(m0_cnt), .tg_cnt(tg_cnt));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 v = rdata;
  endtask : rd
  task automatic t_reset();
    logic [7:0] v;
    for (int i = 0; i < 5; i++) begin
      rd(5'(i * 4 + 1), v); chk(16'(v), 16'h00ff, 16'h00ff);
      rd(5'(i * 4), v); chk(16'(v), 16'h0000, 16'h0000);
      rd(5'(i * 4 + 2), v); chk(16'(v), 16'h0000, 16'h0000);
    end
    rd(5'h03, v); chk(16'(v), 16'h0000, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_rw();
    logic [7:0] v;
    for (int i = 0; i < 5; i++) begin
      wr(5'(i * 4 + 1), 8'(8'h10 + i));
      wr(5'(i * 4), 8'(8'h20 + i));
    end
    for (int i = 0; i < 5; i++) begin
      rd(5'(i * 4 + 1), v); chk(16'(v), 16'(8'h10 + i), 16'(8'h10 + i));
      rd(5'(i * 4), v); chk(16'(v), 16'(8'h20 + i), 16'(8'h20 + i));
    end
    $display("test register access done");
  endtask : t_rw
  task automatic t_prescale();
    logic [7:0] v;
    logic [7:0] w;
    wr(5'h01, 8'hff);
    for (int p = 0; p < 4; p++) begin
      wr(5'h00, 8'h00);
      wr(5'h02, {6'h01, 2'(p)});
      // instruction tick is four clocks, so five prescaled ticks take 20 x ratio
      repeat (20 * (1 << (2 * p)) + 2) @(posedge clk);
      wr(5'h02, {6'h00, 2'(p)});
      rd(5'h00, v); chk(16'(v), 16'h0004, 16'h0007);
    end
    repeat (20) @(posedge clk);
    rd(5'h00, w); chk(16'(w), 16'(v), 16'(v));
    $display("test prescale done");
  endtask : t_prescale
  task automatic t_sleep();
    logic [7:0] v;
    logic [7:0] w;
    wr(5'h00, 8'h00);
    @(posedge clk);
    sleep <= 1'b1;
    wr(5'h02, 8'h04);
    repeat (40) @(posedge clk);
    rd(5'h00, v); chk(16'(v), 16'h0000, 16'h0000);
    rd(5'h01, v); chk(16'(v), 16'h00ff, 16'h00ff);
    @(posedge clk);
    sleep <= 1'b0;
    repeat (40) @(posedge clk);
    rd(5'h00, v); chk(16'(v), 16'h0009, 16'h000b);
    // clock enable low freezes the timer; only edges around the gap may tick
    @(posedge clk);
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    ce <= 1'b1;
    rd(5'h00, w); chk(16'(w), 16'(v), 16'(v) + 16'h0001);
    $display("test sleep done");
  endtask : t_sleep
  task automatic t_post();
    int n;
    logic [7:0] v;
    logic [3:0] ns [3] = '{4'h0, 4'h3, 4'hf};
    wr(5'h01, 8'h00);
    wr(5'h00, 8'h00);
    wr(5'h05, 8'h00);
    wr(5'h04, 8'h00);
    wr(5'h06, 8'h04);
    wr(5'h15, 8'h01);
    foreach (ns[k]) begin
      wr(5'h02, 8'h00);
      wr(5'h14, 8'h00);
      repeat (2) @(posedge clk);
      chk(16'(irq_req[0]), 16'h0000, 16'h0000);
      wr(5'h02, {1'b0, ns[k], 3'h4});
      n = 0;
      for (int c = 0; c <= 200 && irq_req[0] !== 1'b1; c++) begin
        if (c == 200) begin
          failures++;
          break;
        end
        @(posedge clk);
        #1 n += int'(match_pulse[0] === 1'b1);
      end
      chk(16'(n), 16'(ns[k]) + 16'h0001, 16'(ns[k]) + 16'h0001);
    end
    repeat (30) @(posedge clk);
    chk(16'(irq_req[0]), 16'h0001, 16'h0001);
    chk(16'(irq_req[4:1]), 16'h0000, 16'h0000);
    rd(5'h14, v); chk(16'(v), 16'h0003, 16'h0003);
    wr(5'h15, 8'h00);
    repeat (2) @(posedge clk);
    chk(16'(irq_req[0]), 16'h0000, 16'h0000);
    wr(5'h02, 8'h00);
    wr(5'h06, 8'h00);
    repeat (8) @(posedge clk);
    chk(tg_cnt, m0_cnt, m0_cnt);
    $display("test postscale done");
  endtask : t_post
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_rw();
    t_prescale();
    t_sleep();
    t_post();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
